// ===== hw/link_sync.sv
// Two-flop synchroniser for pins arriving from the link
`timescale 1ns/10ps
`default_nettype none
module link_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] din,
    output var  logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_reg <= '0;
            dout     <= '0;
        end else if (ce) begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule // link_sync
`default_nettype wire

// ===== hw/mode_word_controller.sv
// Controller end: register port, link clock divider, command sequencing
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module mode_word_controller
    import dram_mode_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        ce,
    ddr_mode_link.controller_end link,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output var  logic [31:0] rdata
);
    typedef enum logic [1:0] {C_IDLE, C_WRITE_WAIT, C_SELF_REF} ctl_state_t;

    ctl_state_t           state_reg;
    logic [2:0]           div_reg;
    logic [WORD_W-1:0]    mode_reg;
    logic [4:0]           cfg_reg;
    logic                 data_bit_reg;
    logic                 mrs_pend_reg, wr_pend_reg, sre_pend_reg, srx_pend_reg, ref_pend_reg;
    logic                 refused_reg;
    logic [REF_CNT_W-1:0] ref_cnt_reg;
    logic [WL_W-1:0]      wl_cnt_reg;

    wire         fall_tick  = div_reg == 3'(CK_DIV - 1);
    wire         rise_tick  = div_reg == 3'(CK_DIV / 2 - 1);
    wire         idle_tick  = fall_tick & (state_reg == C_IDLE);
    wire         hot        = cfg_reg[CFG_HOT_BIT];
    wire         srt_set    = mode_reg[SRT_BIT];
    wire [WL_W-1:0] wl_total = WL_W'(cfg_reg[4:1])
                               + WL_W'(cwl_cycles(mode_reg[CWL_LSB +: CWL_W])); // RL12

    // Register decode
    wire         wr_mode    = wr & (addr == REG_MODE);
    wire         wr_cmd     = wr & (addr == REG_CMD);
    wire         wr_cfg     = wr & (addr == REG_CFG);
    wire         wr_status  = wr & (addr == REG_STATUS);

    // Issue priority: mode load, write, self-refresh, refresh
    wire         issue_mrs  = idle_tick & mrs_pend_reg;
    wire         issue_wr   = idle_tick & ~mrs_pend_reg & wr_pend_reg;
    wire         try_sre    = idle_tick & ~mrs_pend_reg & ~wr_pend_reg & sre_pend_reg;
    wire         refuse_sre = try_sre & hot & ~srt_set; // RL17
    wire         issue_sre  = try_sre & ~refuse_sre;
    wire         issue_ref  = idle_tick & ~mrs_pend_reg & ~wr_pend_reg & ~sre_pend_reg
                              & ref_pend_reg;
    wire         issue_srx  = fall_tick & (state_reg == C_SELF_REF) & srx_pend_reg;
    wire [REF_CNT_W-1:0] ref_limit = hot ? REFRESH_HOT_CYCLES : REFRESH_CYCLES; // RL16
    wire         ref_due    = (ref_cnt_reg == ref_limit - REF_CNT_W'(1))
                              & (state_reg != C_SELF_REF);

    wire [31:0]  rd_status  = {29'h0, refused_reg, state_reg == C_SELF_REF,
                               state_reg != C_IDLE};
    wire [31:0]  rd_mux     = (addr == REG_MODE)   ? {17'h0, mode_reg} :
                              (addr == REG_CMD)    ? {28'h0, srx_pend_reg, sre_pend_reg,
                                                      data_bit_reg, wr_pend_reg} :
                              (addr == REG_CFG)    ? {27'h0, cfg_reg} :
                              (addr == REG_STATUS) ? rd_status : 32'h0000_0000;

    // Register port; reserved word bits are forced low here
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_reg     <= MODE_RESET;
            cfg_reg      <= CFG_RESET;
            data_bit_reg <= 1'b0;
            rdata        <= 32'h0000_0000;
        end else if (ce) begin
            if (wr_mode) mode_reg <= wdata[WORD_W-1:0] & ~RESERVED_MASK; // RL2
            if (wr_cfg) cfg_reg <= {wdata[CFG_AL_LSB +: AL_W], wdata[CFG_HOT_BIT]};
            if (wr_cmd && wdata[CMD_WRITE_BIT]) data_bit_reg <= wdata[CMD_DATA_BIT];
            rdata <= rd ? rd_mux : 32'h0000_0000;
        end
    end

    // Pending flags: a new request wins over its own issue
    always_ff @(posedge clk) begin
        if (reset) begin
            mrs_pend_reg <= 1'b0;
            wr_pend_reg  <= 1'b0;
            sre_pend_reg <= 1'b0;
            srx_pend_reg <= 1'b0;
            ref_pend_reg <= 1'b0;
            refused_reg  <= 1'b0;
        end else if (ce) begin
            mrs_pend_reg <= wr_mode | (mrs_pend_reg & ~issue_mrs);
            wr_pend_reg  <= (wr_cmd & wdata[CMD_WRITE_BIT]) | (wr_pend_reg & ~issue_wr);
            sre_pend_reg <= (wr_cmd & wdata[CMD_SRE_BIT]) | (sre_pend_reg & ~try_sre);
            srx_pend_reg <= (wr_cmd & wdata[CMD_SRX_BIT]) | (srx_pend_reg & ~issue_srx);
            ref_pend_reg <= ref_due | (ref_pend_reg & ~issue_ref); // RL8
            refused_reg  <= refuse_sre | (refused_reg & ~(wr_status & wdata[STAT_REF_BIT]));
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ref_cnt_reg <= '0;
        end else if (ce) begin
            ref_cnt_reg <= (ref_due || state_reg == C_SELF_REF) ? '0
                                                                : ref_cnt_reg + REF_CNT_W'(1);
        end
    end

    // Link clock divider; pins change only at its falling edge
    always_ff @(posedge clk) begin
        if (reset) begin
            div_reg <= 3'h0;
            link.ck <= 1'b0;
        end else if (ce) begin
            div_reg <= fall_tick ? 3'h0 : div_reg + 3'h1;
            if (fall_tick) link.ck <= 1'b0;
            else if (rise_tick) link.ck <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg  <= C_IDLE;
            wl_cnt_reg <= '0;
            link.cke   <= 1'b1;
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_NOP;
            link.ba    <= BANK_ZERO;
            link.addr  <= 15'h0000;
            link.odt   <= 1'b0;
            link.dq    <= 1'b0;
        end else if (ce && fall_tick) begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_NOP;
            link.ba   <= BANK_ZERO;
            link.addr <= 15'h0000;
            unique case (state_reg)
                C_IDLE: begin
                    if (issue_mrs) begin
                        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_MRS; // RL1
                        link.ba   <= MRS_BANK;
                        link.addr <= mode_reg;
                    end else if (issue_wr) begin
                        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_WRITE;
                        wl_cnt_reg <= wl_total;
                        link.odt   <= 1'b1;
                        state_reg  <= C_WRITE_WAIT;
                    end else if (issue_sre) begin
                        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_REF;
                        link.cke  <= 1'b0;
                        state_reg <= C_SELF_REF;
                    end else if (issue_ref) begin
                        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_REF;
                    end
                end
                C_WRITE_WAIT: begin
                    // Data driven at the fall before the sampling rise
                    if (wl_cnt_reg == WL_W'(0)) begin
                        link.odt  <= 1'b0;
                        state_reg <= C_IDLE;
                    end else begin
                        wl_cnt_reg <= wl_cnt_reg - WL_W'(1);
                        if (wl_cnt_reg == WL_W'(1)) link.dq <= data_bit_reg; // RL12
                    end
                end
                C_SELF_REF: begin
                    if (issue_srx) begin
                        link.cke  <= 1'b1;
                        state_reg <= C_IDLE;
                    end
                end
            endcase
        end
    end
endmodule // mode_word_controller
`default_nettype wire

// ===== hw/mode_word_device.sv
// Memory device end: mode word decode, write timing, termination and self-refresh
//
// Overview of operation
// [RL1] Controller loads word with MRS, bank 2
// [RL2] Controller keeps reserved word bits at zero
// [RL3] Write termination applies even without nominal
// [RL4] No dynamic termination during write leveling
// [RL5] Write termination field sits in bits 9-10
// [RL6] Field: off, two resistor fractions, reserved
// [RL7] Self-refresh keeps only chosen banks
// [RL8] No loss while refreshed, no self-refresh
// [RL9] Column write delay from bits 3-5
// [RL10] Codes 0-4 give 5 to 9 cycles
// [RL11] Write delays are whole clock cycles
// [RL12] Total write delay is additive plus column
// [RL13] Bit 7 enables high-temperature self-refresh
// [RL14] Disabled: self-refresh at single rate
// [RL15] Enabled: self-refresh at double rate
// [RL16] Controller doubles refresh rate when hot
// [RL17] Hot: set bit 7 or avoid self-refresh
`timescale 1ns/10ps
`default_nettype none
module mode_word_device
    import dram_mode_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 ce,
    ddr_mode_link.device_end          link,
    input  wire logic [AL_W-1:0]      additive_delay,
    input  wire logic                 rtt_nom_enable,
    input  wire logic                 write_leveling,
    output var  logic [WORD_W-1:0]    mode_word,
    output var  logic [3:0]           column_write_delay,
    output var  logic [WL_W-1:0]      total_write_delay,
    output var  logic                 self_refresh_double_rate,
    output var  logic                 self_refresh_active,
    output var  logic [7:0]           retained_banks,
    output var  logic [7:0]           lost_banks,
    output var  term_sel_t            term_sel,
    output var  logic                 write_data_valid,
    output var  logic                 write_data,
    output var  logic                 mode_error
);
    localparam int LINK_W = 26;

    logic [LINK_W-1:0] pins_sync;
    logic              ck_prev_reg;
    logic              burst_reg;
    logic [WL_W-1:0]   wl_cnt_reg;

    // Pins reach logic only through the synchroniser
    link_sync #(
        .WIDTH (LINK_W)
    ) u_link_sync (
        .clk   (clk),
        .reset (reset),
        .ce    (ce),
        .din   ({link.ck, link.cke, link.odt, link.dq, link.cs_n, link.ras_n,
                 link.cas_n, link.we_n, link.ba, link.addr}),
        .dout  (pins_sync)
    );

    wire              s_ck      = pins_sync[25];
    wire              s_cke     = pins_sync[24];
    wire              s_odt     = pins_sync[23];
    wire              s_dq      = pins_sync[22];
    wire [3:0]        s_cmd     = pins_sync[21:18];
    wire [2:0]        s_ba      = pins_sync[17:15];
    wire [14:0]       s_addr    = pins_sync[14:0];

    // Pins all lag alike
    wire              ck_rise   = s_ck & ~ck_prev_reg;

    // Command decode at each link clock rise
    wire              is_mrs    = ck_rise & s_cke & (s_cmd == CMD_MRS)
                                  & (s_ba == MRS_BANK); // RL1

    // Refused mid-burst
    wire              is_write  = ck_rise & s_cke & (s_cmd == CMD_WRITE)
                                  & ~self_refresh_active & ~burst_reg;

    // Self-refresh entry, exit
    wire              is_sre    = ck_rise & ~s_cke & (s_cmd == CMD_REF)
                                  & ~self_refresh_active;
    wire              is_srx    = ck_rise & s_cke & self_refresh_active;

    // Field extraction from the incoming word
    wire [2:0]        new_cwl   = s_addr[CWL_LSB +: CWL_W]; // RL9
    wire [1:0]        new_rtt   = s_addr[RTT_LSB +: RTT_W]; // RL5
    wire [2:0]        new_partial_array_retention  = s_addr[PARTIAL_ARRAY_RETENTION_LSB +: PARTIAL_ARRAY_RETENTION_W];

    // Word legality
    wire              cwl_ok    = new_cwl <= CWL_CODE_MAX; // RL10
    wire              rsvd_bad  = ((s_addr & RESERVED_MASK) != 15'h0000) | s_ba[2]; // RL2
    wire              word_bad  = rsvd_bad | ~cwl_ok | (new_rtt == RTT_WR_RSVD);

    // Stored word fields
    wire [1:0]        rtt_wr    = mode_word[RTT_LSB +: RTT_W];
    wire              srt_en    = mode_word[SRT_BIT];

    // Whole-cycle sum, no half-cycle option exists
    wire [WL_W-1:0]   wl_next   = WL_W'(additive_delay) + WL_W'(column_write_delay); // RL11 RL12

    // Data is sampled on the rise that closes the delay count
    wire              capture   = ck_rise & burst_reg & (wl_cnt_reg == WL_W'(1));

    // Write termination only inside a write burst and never while leveling
    wire              wr_dyn    = burst_reg & ~write_leveling
                                  & ((rtt_wr == RTT_WR_DIV4) | (rtt_wr == RTT_WR_DIV2)); // RL4 RL6
    // Codes 1 and 2 only reach here
    wire term_sel_t   wr_term   = (rtt_wr == RTT_WR_DIV4) ? TERM_WR_DIV4 : TERM_WR_DIV2;

    // Nominal enable does not gate the write value
    wire term_sel_t   term_next = !s_odt         ? TERM_OFF     :
                                  wr_dyn         ? wr_term      : // RL3
                                  rtt_nom_enable ? TERM_NOMINAL :
                                                   TERM_OFF;

    // Last synced clock level
    always_ff @(posedge clk) begin
        if (reset) begin
            ck_prev_reg <= 1'b0;
        end else if (ce) begin
            ck_prev_reg <= s_ck;
        end
    end

    // Mode word storage; a reserved delay code keeps the last legal delay
    // The word is stored as sent
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_word          <= MODE_RESET;
            column_write_delay <= CWL_MIN;
            mode_error         <= 1'b0;
        end else if (ce && is_mrs) begin
            mode_word          <= s_addr;
            mode_error         <= word_bad;
            if (cwl_ok) begin
                column_write_delay <= cwl_cycles(new_cwl); // RL10
            end
        end
    end

    // One clock behind the word
    always_ff @(posedge clk) begin
        if (reset) begin
            total_write_delay        <= WL_W'(CWL_MIN);
            self_refresh_double_rate <= 1'b0;
            retained_banks           <= 8'hFF;
            term_sel                 <= TERM_OFF;
        end else if (ce) begin
            total_write_delay        <= wl_next; // RL12
            self_refresh_double_rate <= srt_en; // RL13 RL14 RL15
            retained_banks           <= partial_array_retention_banks(mode_word[PARTIAL_ARRAY_RETENTION_LSB +: PARTIAL_ARRAY_RETENTION_W]);
            term_sel                 <= term_next;
        end
    end

    // Write burst timing counted in link clock rises
    // Ends at the sampling rise
    always_ff @(posedge clk) begin
        if (reset) begin
            burst_reg  <= 1'b0;
            wl_cnt_reg <= '0;
        end else if (ce) begin
            if (is_write) begin
                burst_reg  <= 1'b1;
                wl_cnt_reg <= total_write_delay; // RL12
            end else if (capture) begin
                burst_reg  <= 1'b0;
                wl_cnt_reg <= '0;
            end else if (ck_rise && burst_reg) begin
                wl_cnt_reg <= wl_cnt_reg - WL_W'(1);
            end
        end
    end

    // Held until the next capture
    always_ff @(posedge clk) begin
        if (reset) begin
            write_data_valid <= 1'b0;
            write_data       <= 1'b0;
        end else if (ce) begin
            write_data_valid <= capture;
            if (capture) begin
                write_data <= s_dq;
            end
        end
    end

    // Banks outside the kept range lose contents on entry only;
    // normal refresh without self-refresh never marks a loss
    always_ff @(posedge clk) begin
        if (reset) begin
            self_refresh_active <= 1'b0;
            lost_banks          <= 8'h00;
        end else if (ce) begin
            if (is_sre) begin
                self_refresh_active <= 1'b1;
                lost_banks          <= lost_banks | ~retained_banks; // RL7 RL8
            end else if (is_srx) begin
                self_refresh_active <= 1'b0;
            end
        end
    end
endmodule // mode_word_device
`default_nettype wire

// ===== pkg/ddr_mode_link.sv
// Command and address link between memory controller and memory device
`timescale 1ns/10ps
`default_nettype none
interface ddr_mode_link;
    logic        ck;
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [14:0] addr;
    logic        odt;
    logic        dq;

    modport controller_end (
        output ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dq
    );
    modport device_end (
        input ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dq
    );
endinterface
`default_nettype wire

// ===== pkg/dram_mode_pkg.sv
// Shared constants and decode helpers for the write latency and refresh mode word
`default_nettype none
package dram_mode_pkg;
    // Mode word layout
    localparam int           WORD_W        = 15;
    localparam int           PARTIAL_ARRAY_RETENTION_LSB      = 0;
    localparam int           PARTIAL_ARRAY_RETENTION_W        = 3;
    localparam int           CWL_LSB       = 3;
    localparam int           CWL_W         = 3;
    localparam int           SRT_BIT       = 7;
    localparam int           RTT_LSB       = 9;
    localparam int           RTT_W         = 2;
    localparam logic [14:0]  RESERVED_MASK = 15'h7940;
    localparam logic [14:0]  MODE_RESET    = 15'h0000;

    // Command pins {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0]   CMD_MRS       = 4'h0;
    localparam logic [3:0]   CMD_REF       = 4'h1;
    localparam logic [3:0]   CMD_WRITE     = 4'h4;
    localparam logic [3:0]   CMD_NOP       = 4'h7;
    localparam logic [2:0]   MRS_BANK      = 3'h2;
    localparam logic [2:0]   BANK_ZERO     = 3'h0;

    // Column write delay decode
    localparam logic [3:0]   CWL_MIN       = 4'h5;
    localparam logic [2:0]   CWL_CODE_MAX  = 3'h4;
    localparam int           AL_W          = 4;
    localparam int           WL_W          = 5;

    // Write termination field codes
    localparam logic [1:0]   RTT_WR_OFF    = 2'h0;
    localparam logic [1:0]   RTT_WR_DIV4   = 2'h1;
    localparam logic [1:0]   RTT_WR_DIV2   = 2'h2;
    localparam logic [1:0]   RTT_WR_RSVD   = 2'h3;

    typedef enum logic [1:0] {
        TERM_OFF,
        TERM_NOMINAL,
        TERM_WR_DIV4,
        TERM_WR_DIV2
    } term_sel_t;

    // Link clock and refresh timing
    localparam int           CK_DIV                  = 8;
    localparam int           CLK_MHZ                 = 50;
    localparam int           REFRESH_INTERVAL_NS     = 7800;
    localparam int           REFRESH_INTERVAL_HOT_NS = 3900;
    localparam int           REF_CNT_W               = 9;
    localparam logic [8:0]   REFRESH_CYCLES     = 9'(REFRESH_INTERVAL_NS * CLK_MHZ / 1000);
    localparam logic [8:0]   REFRESH_HOT_CYCLES = 9'(REFRESH_INTERVAL_HOT_NS * CLK_MHZ / 1000);

    // Controller register map
    localparam logic [7:0]   REG_MODE      = 8'h00;
    localparam logic [7:0]   REG_CMD       = 8'h04;
    localparam logic [7:0]   REG_CFG       = 8'h08;
    localparam logic [7:0]   REG_STATUS    = 8'h0C;
    localparam int           CMD_WRITE_BIT = 0;
    localparam int           CMD_DATA_BIT  = 1;
    localparam int           CMD_SRE_BIT   = 2;
    localparam int           CMD_SRX_BIT   = 3;
    localparam int           CFG_HOT_BIT   = 0;
    localparam int           CFG_AL_LSB    = 4;
    localparam int           STAT_BUSY_BIT = 0;
    localparam int           STAT_SR_BIT   = 1;
    localparam int           STAT_REF_BIT  = 2;
    localparam logic [4:0]   CFG_RESET     = 5'h00;

    function automatic logic [3:0] cwl_cycles(input logic [2:0] code);
        cwl_cycles = (code <= CWL_CODE_MAX) ? CWL_MIN + {1'b0, code} : CWL_MIN;
    endfunction

    // Banks kept alive through self-refresh
    function automatic logic [7:0] partial_array_retention_banks(input logic [2:0] code);
        unique case (code)
            3'h0: partial_array_retention_banks = 8'hFF;
            3'h1: partial_array_retention_banks = 8'h0F;
            3'h2: partial_array_retention_banks = 8'h03;
            3'h3: partial_array_retention_banks = 8'h01;
            3'h4: partial_array_retention_banks = 8'hFC;
            3'h5: partial_array_retention_banks = 8'hF0;
            3'h6: partial_array_retention_banks = 8'hC0;
            3'h7: partial_array_retention_banks = 8'h80;
        endcase
    endfunction
endpackage
`default_nettype wire

// ===== testbench/mode_link_chk.sv
// Checker for the mode link commands and the device decode outputs
`timescale 1ns/10ps
`default_nettype none
module mode_link_chk
    import dram_mode_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        cke,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [2:0]  ba,
    input wire logic [14:0] addr,
    input wire logic [3:0]  additive_delay,
    input wire logic        write_leveling,
    input wire logic [14:0] mode_word,
    input wire logic [3:0]  column_write_delay,
    input wire logic [4:0]  total_write_delay,
    input wire logic        self_refresh_double_rate,
    input wire logic        self_refresh_active,
    input wire logic [7:0]  retained_banks,
    input wire logic [7:0]  lost_banks,
    input wire term_sel_t   term_sel
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire mrs = !cs_n && !ras_n && !cas_n && !we_n && cke;
    a_mrs_bank: assert property (mrs |-> ba == MRS_BANK)
        else $error("mode set on wrong bank");
    a_mrs_reserved: assert property (mrs |-> (addr & RESERVED_MASK) == 15'h0000)
        else $error("reserved mode bits driven");
    a_level_no_dyn: assert property (write_leveling && $past(write_leveling)
        |-> term_sel inside {TERM_OFF, TERM_NOMINAL}) else $error("dynamic term in leveling");
    a_term_code: assert property (term_sel inside {TERM_WR_DIV4, TERM_WR_DIV2}
        |-> mode_word[10:9] == (term_sel == TERM_WR_DIV4 ? RTT_WR_DIV4 : RTT_WR_DIV2))
        else $error("write term not from field");
    a_cwl_decode: assert property ($stable(mode_word) [*2] ##0 mode_word[5:3] <= CWL_CODE_MAX
        |-> column_write_delay == CWL_MIN + 4'(mode_word[5:3])) else $error("column delay decode");
    a_total_sum: assert property (!$past(reset) |-> total_write_delay
        == $past(5'(additive_delay) + 5'(column_write_delay))) else $error("total delay sum");
    a_srt_rate: assert property ($stable(mode_word)
        |-> self_refresh_double_rate == mode_word[SRT_BIT]) else $error("refresh rate bit");
    a_lost_sticky: assert property (($past(lost_banks) & ~lost_banks) == 8'h00)
        else $error("lost banks cleared");
    a_lost_entry: assert property ($rose(self_refresh_active)
        |-> ##[0:2] (lost_banks & ~retained_banks) == ~retained_banks) else $error("lost banks");
    c_mrs: cover property (mrs);
    c_sr: cover property ($rose(self_refresh_active));
    c_wr_term: cover property (term_sel == TERM_WR_DIV4);
endmodule // mode_link_chk
`default_nettype wire

// ===== testbench/tb_dram_write_latency_refresh_cfg.sv
// Testbench joining controller and device across the mode link
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("BAD %0t %h %h", $time, (a), (b)); end end
module tb_dram_write_latency_refresh_cfg
    import dram_mode_pkg::*;
;
    logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd_val, w;
    logic [3:0] additive_delay = 4'h3, column_write_delay;
    logic rtt_nom_enable = 1'b0, write_leveling = 1'b0, self_refresh_double_rate;
    logic self_refresh_active, write_data_valid, write_data, mode_error;
    logic [14:0] mode_word;
    logic [4:0] total_write_delay;
    logic [7:0] retained_banks, lost_banks;
    term_sel_t term_sel;
    int fail_count = 0, num_checks = 0, cyc = 0, k, seen_wr = 0, pulses = 0;
    ddr_mode_link ddr_mode_link_i ();
    mode_word_controller mode_word_controller_i (.clk, .reset, .ce(1'b1),
        .link(ddr_mode_link_i), .addr, .wdata, .wr, .rd, .rdata);
    mode_word_device mode_word_device_i (.clk, .reset, .ce(1'b1), .link(ddr_mode_link_i),
        .additive_delay, .rtt_nom_enable, .write_leveling, .mode_word, .column_write_delay,
        .total_write_delay, .self_refresh_double_rate, .self_refresh_active, .retained_banks,
        .lost_banks, .term_sel, .write_data_valid, .write_data, .mode_error);
    mode_link_chk mode_link_chk_i (.clk, .reset, .cke(ddr_mode_link_i.cke),
        .cs_n(ddr_mode_link_i.cs_n), .ras_n(ddr_mode_link_i.ras_n), .cas_n(ddr_mode_link_i.cas_n),
        .we_n(ddr_mode_link_i.we_n), .ba(ddr_mode_link_i.ba), .addr(ddr_mode_link_i.addr),
        .additive_delay, .write_leveling, .mode_word, .column_write_delay, .total_write_delay,
        .self_refresh_double_rate, .self_refresh_active, .retained_banks, .lost_banks, .term_sel);
    always #10 clk = ~clk;
    always @(posedge clk) begin
        seen_wr += (term_sel === TERM_WR_DIV4);
        pulses += write_data_valid;
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 rd_val = rdata;
    endtask
    // Pending commands show no busy, so let them issue first
    task automatic idle;
        repeat (16) @(posedge clk);
        for (int i = 0; i < 300; i++) begin
            rreg(REG_STATUS);
            if (rd_val[STAT_BUSY_BIT] === 1'b0) break;
        end
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic wait_sr(input logic v);
        for (int i = 0; i < 100 && self_refresh_active !== v; i++) @(posedge clk);
        #1;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        #1 `CHK(column_write_delay, 4'h5)
        `CHK(retained_banks, 8'hFF)
        wreg(REG_CFG, 32'h30);
        for (k = 0; k < 5; k++) begin
            w = 32'h201 | 32'(k << 3) | 32'((k & 1) << 7);
            wreg(REG_MODE, w);
            idle();
            `CHK(mode_word, w[14:0])
            `CHK(column_write_delay, 4'(5 + k))
            `CHK(total_write_delay, 5'(8 + k))
            `CHK(self_refresh_double_rate, k[0])
        end
        wreg(REG_MODE, 32'h7FFF);
        idle();
        `CHK(mode_word, 15'h06BF)
        `CHK(mode_error, 1'b1)
        `CHK(column_write_delay, 4'h9)
        wreg(REG_MODE, 32'h209);
        idle();
        `CHK(mode_error, 1'b0)
        wreg(REG_CMD, 32'h3);
        idle();
        `CHK(write_data, 1'b1)
        `CHK(pulses, 1)
        `CHK(seen_wr > 0, 1'b1)
        write_leveling <= 1'b1;
        k = seen_wr;
        wreg(REG_CMD, 32'h1);
        idle();
        `CHK(write_data, 1'b0)
        `CHK(pulses, 2)
        `CHK(seen_wr, k)
        write_leveling <= 1'b0;
        // Hot with the rate bit clear must refuse entry
        wreg(REG_CFG, 32'h31);
        wreg(REG_CMD, 32'h4);
        idle();
        `CHK(rd_val[STAT_REF_BIT], 1'b1)
        `CHK(self_refresh_active, 1'b0)
        wreg(REG_STATUS, 32'h4);
        rreg(REG_STATUS);
        `CHK(rd_val[STAT_REF_BIT], 1'b0)
        wreg(REG_MODE, 32'h289);
        idle();
        wreg(REG_CMD, 32'h4);
        wait_sr(1'b1);
        `CHK(self_refresh_active, 1'b1)
        `CHK(lost_banks, 8'hF0)
        wreg(REG_CMD, 32'h8);
        wait_sr(1'b0);
        `CHK(self_refresh_active, 1'b0)
        `CHK(lost_banks, 8'hF0)
        rreg(8'h10);
        `CHK(rd_val, 32'h0)
        complete_run();
    end
endmodule // tb_dram_write_latency_refresh_cfg
`default_nettype wire
